// file: rtl/aics_rate_meter.sv
`timescale 1ns/1ps
module aics_rate_meter
	import aics_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ref_edge,
	input wire logic frame_edge,
	output aics_ratio_type ratio,
	output logic ratio_valid
);

	// ***********************************
	// edges per frame counter
	// ***********************************
	logic [11:0] cnt_q;
	logic [11:0] cnt_d;
	logic [11:0] cnt_inc;
	aics_ratio_type class_now;

	assign cnt_inc = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + CNT_ONE;
	assign cnt_d = frame_edge ? (ref_edge ? CNT_ONE : '0) : (ref_edge ? cnt_inc : cnt_q);
	assign class_now = aics_classify(cnt_q);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= '0;
			ratio <= RATIO_256;
			ratio_valid <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			if (frame_edge)
			begin
				ratio <= class_now;
				ratio_valid <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_CLASSIFY: assert property (frame_edge |=> ratio == aics_classify($past(cnt_q))) // [R03]
		else $error("ratio does not match measured count");

endmodule : aics_rate_meter

// file: rtl/aics_sync.sv
`timescale 1ns/1ps
module aics_sync
	import aics_pkg::*;
#(
	parameter int W = SYN_W
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	// ***********************************
	// two flop synchroniser
	// ***********************************
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : aics_sync

// file: rtl/aics_top.sv
`timescale 1ns/1ps
// Functional notes
// [R01] adc clock field: 00 adc pin, 01 pll a, 10 pll b, 11 main; reset 00.
// [R02] software avoids pll clocks for the adc while s/pdif receiver runs.
// [R03] primary transmitter carrying adc: adc rate from primary transmit frame clock.
// [R04] else secondary transmitter carrying adc: adc rate from secondary frame clock.
// [R05] only s/pdif transmitter carrying adc: rate from three bit field, reset 010.
// [R06] keep clock sources synchronous where possible for best performance.
// [R07] s/pdif transmit clock field maps like adc field; reset 01.
// [R08] s/pdif receiver uses pll a only; pll clocks then unavailable elsewhere; code withholds only pll b, pll a stays selectable by the fields.
// [R09] s/pdif transmitter carrying received s/pdif: force pll a.
// [R10] that route: transmit rate from receiver subframe clock.
// [R11] primary or secondary receiver routes: rate from that receiver frame clock.
// [R12] adc route: primary transmit frame clock if it carries adc, else field.
// [R13] primary receiver clocks external in slave, generated in master mode.
// [R14] primary receiver master clock field: 00/11 main, 01 pll a, 10 pll b.
// [R15] primary transmitter master clock: pll a for s/pdif route, else adc clock.
// [R16] software uses master mode for primary transmitter carrying s/pdif data.
// [R17] slave mode with adc on main pin: primary receive bit clock drives transmitter.
// [R18] secondary port sides share one frame clock and one bit clock; code takes a separate secondary_rx_frame_clock for the receiver route.
// [R19] secondary master clock field maps like adc field; reset 11.
// [R20] secondary transmitter carrying received s/pdif: force pll a.
// [R21] software picks only pin clocks for secondary port while receiver powered.
// [R22] receiver enabled: pll b never routed to any internal function.
module aics_top
	import aics_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [6:0] reg_addr,
	input wire logic [8:0] reg_wdata,
	output logic [8:0] reg_rdata,
	output logic reg_rd_valid,
	input wire logic adc_master_clock_pin,
	input wire logic main_master_clock_pin,
	input wire logic pll_a_clock,
	input wire logic pll_b_clock,
	input wire logic primary_tx_frame_clock,
	input wire logic primary_rx_frame_clock,
	input wire logic secondary_frame_clock,
	input wire logic secondary_rx_frame_clock,
	input wire logic spdif_subframe_clock,
	input wire logic primary_rx_bit_clock,
	input wire logic spdif_rx_active,
	input wire logic primary_tx_master,
	input wire logic [1:0] primary_tx_src,
	input wire logic [1:0] secondary_tx_src,
	input wire logic [1:0] spdif_tx_src,
	output aics_clk_sel_type clock_sel,
	output aics_ratio_type adc_oversample_ratio,
	output aics_ratio_type spdif_tx_ratio,
	output logic primary_tx_bit_from_rx,
	output logic primary_tx_bit_clock
);

	// ***********************************
	// registers
	// ***********************************
	logic [8:0] clock_source_select_q;
	logic [8:0] primary_port_config_one_q;
	logic [8:0] secondary_port_config_one_q;
	logic [8:0] adc_control_one_q;
	logic hit_clk;
	logic hit_pri;
	logic hit_sec;
	logic hit_adc;
	logic [8:0] rdata_d;

	assign hit_clk = reg_addr == OFS_CLOCK_SOURCE_SELECT;
	assign hit_pri = reg_addr == OFS_PRIMARY_PORT_CONFIG_ONE;
	assign hit_sec = reg_addr == OFS_SECONDARY_PORT_CONFIG_ONE;
	assign hit_adc = reg_addr == OFS_ADC_CONTROL_ONE;
	assign rdata_d = hit_clk ? clock_source_select_q :
		hit_pri ? primary_port_config_one_q :
		hit_sec ? secondary_port_config_one_q :
		hit_adc ? adc_control_one_q : RDATA_UNMAPPED;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clock_source_select_q <= RST_CLOCK_SOURCE_SELECT; // [R01] [R07]
			primary_port_config_one_q <= RST_PRIMARY_PORT_CONFIG_ONE; // [R14]
			secondary_port_config_one_q <= RST_SECONDARY_PORT_CONFIG_ONE; // [R19]
			adc_control_one_q <= RST_ADC_CONTROL_ONE; // [R05]
			reg_rdata <= RDATA_UNMAPPED;
			reg_rd_valid <= 1'b0;
		end
		else
		begin
			if (reg_wr_en && hit_clk)
				clock_source_select_q <= reg_wdata;
			if (reg_wr_en && hit_pri)
				primary_port_config_one_q <= reg_wdata;
			if (reg_wr_en && hit_sec)
				secondary_port_config_one_q <= reg_wdata;
			if (reg_wr_en && hit_adc)
				adc_control_one_q <= reg_wdata;
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en)
				reg_rdata <= rdata_d;
		end
	end

	// ***********************************
	// field decode
	// ***********************************
	aics_src_type adc_field;
	aics_src_type spdif_tx_field;
	aics_src_type primary_rx_field;
	aics_src_type secondary_field;
	aics_ratio_type adc_ratio_field;
	logic [1:0] prx_raw;

	assign adc_field = aics_src_type'(clock_source_select_q[ADC_SEL_LSB +: 2]); // [R01]
	assign spdif_tx_field = aics_src_type'(clock_source_select_q[SPDIF_TX_SEL_LSB +: 2]); // [R07]
	assign secondary_field = aics_src_type'(secondary_port_config_one_q[SECONDARY_SEL_LSB +: 2]); // [R19]
	assign adc_ratio_field = aics_ratio_type'(adc_control_one_q[ADC_RATIO_LSB +: 3]); // [R05]
	assign prx_raw = primary_port_config_one_q[PRIMARY_RX_SEL_LSB +: 2];
	// adc pin code means main pin here
	assign primary_rx_field = (prx_raw == SRC_ADC_PIN) ? SRC_MAIN_PIN : aics_src_type'(prx_raw); // [R14]

	// ***********************************
	// clock selection
	// ***********************************
	aics_clk_sel_type sel_d;
	logic ptx_spdif;
	logic stx_spdif;
	logic sptx_spdif;

	assign ptx_spdif = primary_tx_src == PTX_FROM_SPDIF_RX;
	assign stx_spdif = secondary_tx_src == STX_FROM_SPDIF_RX;
	assign sptx_spdif = spdif_tx_src == SPTX_FROM_SPDIF_RX;
	assign sel_d.adc = aics_block_pll_b(adc_field, spdif_rx_active, SRC_ADC_PIN); // [R22]
	assign sel_d.spdif_tx = sptx_spdif ? SRC_PLL_A :
		aics_block_pll_b(spdif_tx_field, spdif_rx_active, SRC_ADC_PIN); // [R09] [R08]
	assign sel_d.primary_rx = aics_block_pll_b(primary_rx_field, spdif_rx_active,
		SRC_MAIN_PIN); // [R13] [R22]
	assign sel_d.primary_tx = ptx_spdif ? SRC_PLL_A : sel_d.adc; // [R15]
	assign sel_d.secondary = stx_spdif ? SRC_PLL_A :
		aics_block_pll_b(secondary_field, spdif_rx_active, SRC_ADC_PIN); // [R20] [R18]

	// ***********************************
	// pin sampling
	// ***********************************
	logic [9:0] pins_raw;
	logic [9:0] pins_s;
	logic [9:0] pins_prev_q;
	logic [9:0] pins_rise;

	assign pins_raw = {primary_rx_bit_clock, spdif_subframe_clock, secondary_rx_frame_clock,
		secondary_frame_clock, primary_rx_frame_clock, primary_tx_frame_clock,
		main_master_clock_pin, pll_b_clock, pll_a_clock, adc_master_clock_pin};
	assign pins_rise = pins_s & ~pins_prev_q;

	aics_sync #(.W(SYN_W)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);

	// ***********************************
	// rate measurement
	// ***********************************
	logic [3:0] mclk_rise;
	logic adc_ref_edge;
	logic adc_frame_edge;
	logic sptx_ref_edge;
	logic sptx_frame_edge;
	logic ptx_adc;
	logic stx_adc;
	logic sptx_adc;
	aics_ratio_type adc_meas;
	aics_ratio_type sptx_meas;
	aics_ratio_type adc_ratio_d;
	aics_ratio_type sptx_ratio_d;

	assign mclk_rise = pins_rise[SYN_MCLK_LSB +: 4];
	assign ptx_adc = primary_tx_src == PTX_FROM_ADC;
	assign stx_adc = secondary_tx_src == STX_FROM_ADC;
	assign sptx_adc = spdif_tx_src == SPTX_FROM_ADC;
	assign adc_ref_edge = mclk_rise[sel_d.adc];
	assign sptx_ref_edge = mclk_rise[sel_d.spdif_tx];
	assign adc_frame_edge = ptx_adc ? pins_rise[SYN_PTX_FRAME] :
		pins_rise[SYN_SEC_FRAME]; // [R03] [R04]
	assign sptx_frame_edge = sptx_spdif ? pins_rise[SYN_SUBFRAME] : // [R10]
		(spdif_tx_src == SPTX_FROM_PRIMARY) ? pins_rise[SYN_PRX_FRAME] : // [R11]
		(spdif_tx_src == SPTX_FROM_SECONDARY) ? pins_rise[SYN_SRX_FRAME] :
		pins_rise[SYN_PTX_FRAME]; // [R12]
	assign adc_ratio_d = (ptx_adc || stx_adc) ? adc_meas : adc_ratio_field; // [R05]
	assign sptx_ratio_d = (sptx_adc && !ptx_adc) ? adc_ratio_field : sptx_meas; // [R12]

	aics_rate_meter u_adc_meter (
		.clk(clk),
		.rst_n(rst_n),
		.ref_edge(adc_ref_edge),
		.frame_edge(adc_frame_edge),
		.ratio(adc_meas),
		.ratio_valid()
	);

	aics_rate_meter u_sptx_meter (
		.clk(clk),
		.rst_n(rst_n),
		.ref_edge(sptx_ref_edge),
		.frame_edge(sptx_frame_edge),
		.ratio(sptx_meas),
		.ratio_valid()
	);

	// ***********************************
	// output registers
	// ***********************************
	logic bit_from_rx_d;

	assign bit_from_rx_d = !primary_tx_master && sel_d.adc == SRC_MAIN_PIN; // [R17]

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clock_sel <= CLK_SEL_RESET;
			adc_oversample_ratio <= RATIO_256;
			spdif_tx_ratio <= RATIO_256;
			primary_tx_bit_from_rx <= 1'b0;
			primary_tx_bit_clock <= 1'b0;
			pins_prev_q <= '0;
		end
		else
		begin
			clock_sel <= sel_d;
			adc_oversample_ratio <= adc_ratio_d;
			spdif_tx_ratio <= sptx_ratio_d;
			primary_tx_bit_from_rx <= bit_from_rx_d;
			primary_tx_bit_clock <= bit_from_rx_d & pins_s[SYN_PRX_BIT]; // [R17]
			pins_prev_q <= pins_s;
		end
	end

	// ***********************************
	// assertions
	// ***********************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_read_clk;
		reg_rd_en && hit_clk && !reg_wr_en;
	endsequence

	sequence s_answer;
		reg_rd_valid ##0 (reg_rdata == $past(clock_source_select_q));
	endsequence

	AST_SPDIF_TX_PLL_A: assert property (sptx_spdif |=> clock_sel.spdif_tx == SRC_PLL_A) // [R09]
		else $error("s/pdif transmitter not on pll a");
	AST_NO_PLL_B: assert property (spdif_rx_active |=> clock_sel.adc != SRC_PLL_B && // [R22]
		clock_sel.spdif_tx != SRC_PLL_B && clock_sel.primary_rx != SRC_PLL_B &&
		clock_sel.primary_tx != SRC_PLL_B && clock_sel.secondary != SRC_PLL_B)
		else $error("pll b routed while receiver active");
	AST_ADC_MAP: assert property (!spdif_rx_active |=> clock_sel.adc == $past(adc_field)) // [R01]
		else $error("adc clock does not follow field");
	AST_PRX_MAIN: assert property (prx_raw == 2'b00 |=> clock_sel.primary_rx == SRC_MAIN_PIN) // [R14]
		else $error("primary receiver code 00 not main pin");
	AST_SEC_PLL_A: assert property (stx_spdif |=> clock_sel.secondary == SRC_PLL_A) // [R20]
		else $error("secondary port not on pll a");
	AST_PTX_FOLLOW: assert property (!ptx_spdif |=> clock_sel.primary_tx == clock_sel.adc) // [R15]
		else $error("primary transmitter clock differs from adc clock");
	AST_ADC_FIELD: assert property (!ptx_adc && !stx_adc ##1 !ptx_adc && !stx_adc // [R05]
		|=> adc_oversample_ratio == $past(adc_ratio_field))
		else $error("adc ratio not taken from field");
	AST_SPTX_FIELD: assert property (sptx_adc && !ptx_adc |=> // [R12]
		spdif_tx_ratio == $past(adc_ratio_field))
		else $error("s/pdif ratio not taken from field");
	AST_BIT_SRC: assert property (primary_tx_bit_from_rx == // [R17]
		$past(!primary_tx_master && sel_d.adc == SRC_MAIN_PIN) || $past(!rst_n))
		else $error("bit clock source flag wrong");
	AST_READ: assert property (s_read_clk |=> s_answer) // [R07]
		else $error("clock register readback wrong");

endmodule : aics_top

// file: shared/aics_pkg.sv
package aics_pkg;

	// ***********************************
	// register map
	// ***********************************
	localparam int REG_ADDR_W = 7;
	localparam int REG_DATA_W = 9;
	localparam logic [6:0] OFS_CLOCK_SOURCE_SELECT = 7'h08;
	localparam logic [6:0] OFS_PRIMARY_PORT_CONFIG_ONE = 7'h09;
	localparam logic [6:0] OFS_SECONDARY_PORT_CONFIG_ONE = 7'h0b;
	localparam logic [6:0] OFS_ADC_CONTROL_ONE = 7'h1d;

	// field positions
	localparam int ADC_SEL_LSB = 2;
	localparam int SPDIF_TX_SEL_LSB = 4;
	localparam int PRIMARY_RX_SEL_LSB = 6;
	localparam int SECONDARY_SEL_LSB = 6;
	localparam int ADC_RATIO_LSB = 5;

	// reset values, whole registers
	localparam logic [8:0] RST_CLOCK_SOURCE_SELECT = 9'h010;
	localparam logic [8:0] RST_PRIMARY_PORT_CONFIG_ONE = 9'h000;
	localparam logic [8:0] RST_SECONDARY_PORT_CONFIG_ONE = 9'h0c0;
	localparam logic [8:0] RST_ADC_CONTROL_ONE = 9'h040;
	localparam logic [8:0] RDATA_UNMAPPED = 9'h000;

	// ***********************************
	// clock sources and selections
	// ***********************************
	typedef enum logic [1:0] {
		SRC_ADC_PIN = 2'b00,
		SRC_PLL_A = 2'b01,
		SRC_PLL_B = 2'b10,
		SRC_MAIN_PIN = 2'b11
	} aics_src_type;

	typedef struct packed {
		aics_src_type adc;
		aics_src_type spdif_tx;
		aics_src_type primary_rx;
		aics_src_type primary_tx;
		aics_src_type secondary;
	} aics_clk_sel_type;

	localparam aics_clk_sel_type CLK_SEL_RESET = '{SRC_ADC_PIN, SRC_PLL_A, SRC_MAIN_PIN,
		SRC_ADC_PIN, SRC_MAIN_PIN};

	// ***********************************
	// routing source codes
	// ***********************************
	localparam logic [1:0] PTX_FROM_SPDIF_RX = 2'b00;
	localparam logic [1:0] PTX_FROM_ADC = 2'b01;
	localparam logic [1:0] STX_FROM_SPDIF_RX = 2'b00;
	localparam logic [1:0] STX_FROM_ADC = 2'b01;
	localparam logic [1:0] SPTX_FROM_SPDIF_RX = 2'b00;
	localparam logic [1:0] SPTX_FROM_ADC = 2'b01;
	localparam logic [1:0] SPTX_FROM_SECONDARY = 2'b10;
	localparam logic [1:0] SPTX_FROM_PRIMARY = 2'b11;

	// ***********************************
	// oversampling ratios
	// ***********************************
	typedef enum logic [2:0] {
		RATIO_128 = 3'b000,
		RATIO_192 = 3'b001,
		RATIO_256 = 3'b010,
		RATIO_384 = 3'b011,
		RATIO_512 = 3'b100,
		RATIO_768 = 3'b101,
		RATIO_1152 = 3'b110
	} aics_ratio_type;

	localparam int CNT_W = 12;
	localparam logic [11:0] CNT_MAX = 12'hfff;
	localparam logic [11:0] CNT_ONE = 12'h001;
	// midpoints between neighbouring ratios
	localparam logic [11:0] THR_160 = 12'h0a0;
	localparam logic [11:0] THR_224 = 12'h0e0;
	localparam logic [11:0] THR_320 = 12'h140;
	localparam logic [11:0] THR_448 = 12'h1c0;
	localparam logic [11:0] THR_640 = 12'h280;
	localparam logic [11:0] THR_960 = 12'h3c0;

	// nearest ratio to a count of master clock edges per frame
	function automatic aics_ratio_type aics_classify(input logic [11:0] cnt);
		aics_ratio_type r;
		r = RATIO_1152;
		if (cnt < THR_160)
			r = RATIO_128;
		else if (cnt < THR_224)
			r = RATIO_192;
		else if (cnt < THR_320)
			r = RATIO_256;
		else if (cnt < THR_448)
			r = RATIO_384;
		else if (cnt < THR_640)
			r = RATIO_512;
		else if (cnt < THR_960)
			r = RATIO_768;
		return r;
	endfunction : aics_classify

	// pll b withheld while the s/pdif receiver runs
	function automatic aics_src_type aics_block_pll_b(input aics_src_type sel,
		input logic rx_active, input aics_src_type fallback);
		return (rx_active && sel == SRC_PLL_B) ? fallback : sel;
	endfunction : aics_block_pll_b

	// sync vector layout
	localparam int SYN_W = 10;
	localparam int SYN_MCLK_LSB = 0;
	localparam int SYN_PTX_FRAME = 4;
	localparam int SYN_PRX_FRAME = 5;
	localparam int SYN_SEC_FRAME = 6;
	localparam int SYN_SRX_FRAME = 7;
	localparam int SYN_SUBFRAME = 8;
	localparam int SYN_PRX_BIT = 9;

endpackage : aics_pkg

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import aics_pkg::*;
();

	// ***********************************
	// signals
	// ***********************************
	logic clk;
	logic rst_n;
	logic reg_wr_en;
	logic reg_rd_en;
	logic [6:0] reg_addr;
	logic [8:0] reg_wdata;
	logic [8:0] reg_rdata;
	logic reg_rd_valid;
	logic mck;
	logic ptx_fr;
	logic prx_fr;
	logic sec_fr;
	logic srx_fr;
	logic sub_fr;
	logic prx_bit;
	logic rx_act;
	logic ptx_master;
	logic [1:0] ptx_src;
	logic [1:0] stx_src;
	logic [1:0] sptx_src;
	aics_clk_sel_type clock_sel;
	aics_ratio_type adc_ratio;
	aics_ratio_type sptx_ratio;
	logic bit_from_rx;
	logic ptx_bit;
	int unsigned cyc = 0;
	int err_count;
	int checks;

	aics_top u_dut (
		.clk(clk),
		.rst_n(rst_n),
		.reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid),
		.adc_master_clock_pin(mck),
		.main_master_clock_pin(mck),
		.pll_a_clock(mck),
		.pll_b_clock(mck),
		.primary_tx_frame_clock(ptx_fr),
		.primary_rx_frame_clock(prx_fr),
		.secondary_frame_clock(sec_fr),
		.secondary_rx_frame_clock(srx_fr),
		.spdif_subframe_clock(sub_fr),
		.primary_rx_bit_clock(prx_bit),
		.spdif_rx_active(rx_act),
		.primary_tx_master(ptx_master),
		.primary_tx_src(ptx_src),
		.secondary_tx_src(stx_src),
		.spdif_tx_src(sptx_src),
		.clock_sel(clock_sel),
		.adc_oversample_ratio(adc_ratio),
		.spdif_tx_ratio(sptx_ratio),
		.primary_tx_bit_from_rx(bit_from_rx),
		.primary_tx_bit_clock(ptx_bit)
	);

	// ***********************************
	// clock and stimulus clocks
	// ***********************************
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// master clock at a quarter of clk, frames sized for known ratios
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		mck <= cyc[1];
		prx_bit <= cyc[2];
		ptx_fr <= (cyc % 1536) < 768;
		prx_fr <= (cyc % 512) < 256;
		sec_fr <= (cyc % 3072) < 1536;
		srx_fr <= (cyc % 2048) < 1024;
		sub_fr <= (cyc % 768) < 384;
	end

	// ***********************************
	// helpers
	// ***********************************
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic reg_write(input logic [6:0] a, input logic [8:0] d);
		@(posedge clk);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr_en <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [6:0] a, input logic [8:0] exp);
		@(posedge clk);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd_en <= 1'b0;
		#1;
		check({9'h000, reg_rd_valid}, 10'h001);
		check({1'b0, reg_rdata}, {1'b0, exp});
	endtask : reg_read

	// pin clocks only while the s/pdif receiver runs
	function automatic logic [1:0] legal(input logic [1:0] f, input logic rx);
		return rx ? {f[1], f[1]} : f;
	endfunction : legal

	function automatic aics_src_type blk(input logic [1:0] f, input logic rx);
		return (rx && f == 2'b10) ? SRC_ADC_PIN : aics_src_type'(f);
	endfunction : blk

	function automatic aics_clk_sel_type exp_sel(input logic [8:0] r8, input logic [8:0] r9,
		input logic [8:0] rb, input logic rx);
		aics_clk_sel_type e;
		e.adc = blk(r8[3:2], rx);
		e.spdif_tx = (sptx_src == 2'b00) ? SRC_PLL_A : blk(r8[5:4], rx);
		e.primary_rx = (r9[7:6] == 2'b01) ? SRC_PLL_A : SRC_MAIN_PIN;
		if (r9[7:6] == 2'b10 && !rx)
			e.primary_rx = SRC_PLL_B;
		e.primary_tx = (ptx_src == 2'b00) ? SRC_PLL_A : e.adc;
		e.secondary = (stx_src == 2'b00) ? SRC_PLL_A : blk(rb[7:6], rx);
		return e;
	endfunction : exp_sel

	task automatic rate_case(input logic [1:0] p, input logic [1:0] s, input logic [1:0] t,
		input aics_ratio_type ea, input aics_ratio_type es);
		@(posedge clk);
		ptx_src <= p;
		stx_src <= s;
		sptx_src <= t;
		repeat (9300) @(posedge clk);
		#1;
		check({7'h00, adc_ratio}, {7'h00, ea});
		check({7'h00, sptx_ratio}, {7'h00, es});
	endtask : rate_case

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	// ***********************************
	// watchdog
	// ***********************************
	initial
	begin
		#1_000_000;
		err_count++;
		test_done;
	end

	// ***********************************
	// main sequence
	// ***********************************
	initial
	begin : main_seq
		logic [8:0] r8;
		logic [8:0] r9;
		logic [8:0] rb;
		logic rx;
		logic [1:0] stx_tab [3];
		aics_clk_sel_type es;
		logic [1:0] ps;
		logic b;
		stx_tab = '{2'b00, 2'b01, 2'b11};
		err_count = 0;
		checks = 0;
		rst_n = 1'b0;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 7'h00;
		reg_wdata = 9'h000;
		rx_act = 1'b0;
		ptx_master = 1'b0;
		ptx_src = 2'b01;
		stx_src = 2'b01;
		sptx_src = 2'b01;
		void'($urandom(32'ha0e0));
		repeat (5) @(posedge clk);
		#1;
		check(clock_sel, CLK_SEL_RESET);
		check({7'h00, adc_ratio}, {7'h00, RATIO_256});
		check({7'h00, sptx_ratio}, {7'h00, RATIO_256});
		check({9'h000, bit_from_rx}, 10'h000);
		@(posedge clk);
		rst_n <= 1'b1;
		reg_read(OFS_CLOCK_SOURCE_SELECT, RST_CLOCK_SOURCE_SELECT);
		reg_read(OFS_PRIMARY_PORT_CONFIG_ONE, RST_PRIMARY_PORT_CONFIG_ONE);
		reg_read(OFS_SECONDARY_PORT_CONFIG_ONE, RST_SECONDARY_PORT_CONFIG_ONE);
		reg_read(OFS_ADC_CONTROL_ONE, RST_ADC_CONTROL_ONE);
		reg_write(7'h0a, 9'h1ff);
		reg_read(7'h0a, RDATA_UNMAPPED);
		// random selections with receiver on and off
		repeat (40)
		begin
			rx = 1'($urandom);
			r8 = 9'($urandom);
			r8[3:2] = legal(r8[3:2], rx);
			r8[5:4] = legal(r8[5:4], rx);
			r9 = 9'($urandom);
			r9[7:6] = legal(r9[7:6], rx);
			rb = 9'($urandom);
			rb[7:6] = legal(rb[7:6], rx);
			reg_write(OFS_CLOCK_SOURCE_SELECT, r8);
			reg_write(OFS_PRIMARY_PORT_CONFIG_ONE, r9);
			reg_write(OFS_SECONDARY_PORT_CONFIG_ONE, rb);
			rx_act <= rx;
			ps = 2'($urandom % 3);
			ptx_src <= ps;
			ptx_master <= (ps == PTX_FROM_SPDIF_RX) || 1'($urandom);
			stx_src <= stx_tab[$urandom % 3];
			sptx_src <= 2'($urandom);
			repeat (4) @(posedge clk);
			#1;
			es = exp_sel(r8, r9, rb, rx);
			check(clock_sel, es);
			check({9'h000, bit_from_rx},
				{9'h000, !ptx_master && es.adc == SRC_MAIN_PIN});
			if (bit_from_rx === 1'b0)
				check({9'h000, ptx_bit}, 10'h000);
			else
			begin
				b = ptx_bit;
				repeat (4) @(posedge clk);
				#1;
				check({9'h000, ptx_bit}, {9'h000, ~b});
			end
			reg_read(OFS_CLOCK_SOURCE_SELECT, r8);
		end
		// rates from frame clocks and from the field
		rx_act <= 1'b0;
		reg_write(OFS_ADC_CONTROL_ONE, {1'b0, RATIO_1152, 5'h00});
		rate_case(2'b01, 2'b00, 2'b01, RATIO_384, RATIO_384);
		rate_case(2'b10, 2'b01, 2'b11, RATIO_768, RATIO_128);
		rate_case(2'b10, 2'b00, 2'b10, RATIO_1152, RATIO_512);
		rate_case(2'b00, 2'b11, 2'b00, RATIO_1152, RATIO_192);
		rate_case(2'b10, 2'b11, 2'b01, RATIO_1152, RATIO_1152);
		for (int k = 0; k < 7; k++)
		begin
			reg_write(OFS_ADC_CONTROL_ONE, {1'($urandom), 3'(k), 5'($urandom)});
			repeat (10) @(posedge clk);
			#1;
			check({7'h00, adc_ratio}, {7'h00, 3'(k)});
			check({7'h00, sptx_ratio}, {7'h00, 3'(k)});
		end
		test_done;
	end

endmodule : tb_top
